// ### common/sac_pkg.sv
/*
 * Shared constants and carriers of the 8-bit successive-approximation
 * converter control block: register map, fields, timing and structs.
 * Assumes a single 25 MHz system clock and an APB register bus.
 */
package sac_pkg;

	localparam int SAC_CLK_HZ = 25_000_000;
	localparam int SAC_DATA_W = 8;
	localparam int SAC_CH_W = 4;
	localparam int SAC_PIN_W = 16;
	localparam int SAC_EV_W = 2;
	localparam int SAC_ADDR_W = 12;
	localparam int SAC_CONV_TICKS = 12;
	localparam int SAC_SAMPLE_TICKS = 4;
	localparam int SAC_STAB_TIME_NS = 1000;
	localparam int SAC_STAB_CYC =
		(SAC_STAB_TIME_NS * (SAC_CLK_HZ / 1_000_000) + 999) / 1000;

	////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [7:0] SAC_RESULT_IDX = 8'h70;
	localparam logic [7:0] SAC_CSR_IDX = 8'h71;
	localparam logic [7:0] SAC_ISTAT_IDX = 8'h72;
	localparam logic [7:0] SAC_ICLR_IDX = 8'h73;
	localparam logic [7:0] SAC_IEN_IDX = 8'h74;
	localparam logic [7:0] SAC_PIN_IDX = 8'h75;
	localparam logic [11:0] SAC_RESULT_ADDR = {2'h0, SAC_RESULT_IDX, 2'h0};
	localparam logic [11:0] SAC_CSR_ADDR = {2'h0, SAC_CSR_IDX, 2'h0};
	localparam logic [11:0] SAC_ISTAT_ADDR = {2'h0, SAC_ISTAT_IDX, 2'h0};
	localparam logic [11:0] SAC_ICLR_ADDR = {2'h0, SAC_ICLR_IDX, 2'h0};
	localparam logic [11:0] SAC_IEN_ADDR = {2'h0, SAC_IEN_IDX, 2'h0};
	localparam logic [11:0] SAC_PIN_ADDR = {2'h0, SAC_PIN_IDX, 2'h0};

	localparam int SAC_DONE_BIT = 7;
	localparam int SAC_ON_BIT = 5;
	localparam int SAC_CH_LSB = 0;
	localparam logic [7:0] SAC_CSR_RESET = 8'h00;
	localparam logic [7:0] SAC_RESULT_RESET = 8'h00;
	localparam logic [7:0] SAC_SAR_FIRST = 8'h80;
	localparam int SAC_EV_DONE = 0;
	localparam int SAC_EV_ABORT = 1;

	typedef enum logic [1:0] {
		SAC_OFF = 2'b00,
		SAC_SAMPLE = 2'b01,
		SAC_CONVERT = 2'b11,
		SAC_STAB = 2'b10
	} sac_state_e;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [SAC_ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} sac_apb_req_s;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} sac_apb_rsp_s;

	typedef struct packed {
		logic power_on;
		logic sample;
		logic [SAC_CH_W-1:0] mux_sel;
		logic [SAC_DATA_W-1:0] dac_code;
	} sac_ana_s;

endpackage : sac_pkg

// ### design/sac_ctrl.sv
/*
 * Control logic of an 8-bit successive-approximation converter with
 * APB registers, continuous conversion, halt handling and an interrupt
 * line. Assumes the analog mux, sample/hold, trial DAC and comparator sit
 * outside; cmp_in is high when the held input is at or above dac_code.
 */
// Notes on behaviour
// - each result is an 8-bit value in a readable result register
// - eight approximation steps, one bit each, input isolated meanwhile
// - while on, sampling and approximation repeat with no software help
// - a conversion lasts 12 converter clocks; converter clock is half
// - setting power on starts the first conversion, then runs continuously
// - every conversion end sets the done flag and the done interrupt status bit
// - result holds until the next conversion finishes, then is replaced
// - control write with power on aborts, clears done, restarts; during halt or SAC_STAB it only clears done
// - done clears on result read or control write; not software settable
// - software writes the power-on bit to switch on or off
// - bits 3..0 pick analog input 0 to 15 by binary value
// - input at high reference gives FFh, at low reference gives 00h
// - wait mode has no effect; converter keeps running
// - halt disables converter; a settling interval follows wake-up
// - analog use of a pin leaves its logic level readable
// - control register resets to zero: off, done clear, input 0
module sac_ctrl
	import sac_pkg::*;
#(
	parameter int STAB_CYC = SAC_STAB_CYC
) (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire sac_apb_req_s apb_in,
	output sac_apb_rsp_s apb_out,
	input wire logic cmp_in,
	input wire logic halt_in,
	input wire logic [SAC_PIN_W-1:0] pin_level_in,
	output sac_ana_s ana_out,
	output logic irq_out
);

	localparam int STAB_W = $clog2(STAB_CYC + 1);

	typedef struct packed {
		sac_state_e st;
		logic div;
		logic [3:0] step;
		logic [SAC_DATA_W-1:0] sar;
		logic [SAC_DATA_W-1:0] result;
		logic on;
		logic done;
		logic [SAC_CH_W-1:0] ch;
		logic [SAC_EV_W-1:0] ist;
		logic [SAC_EV_W-1:0] ien;
		logic [SAC_PIN_W-1:0] pins;
		logic [STAB_W-1:0] stab;
		logic evt_done;
		sac_apb_rsp_s rsp;
		sac_ana_s ana;
		logic irq;
	} sac_reg_s;

	logic rst_meta;
	logic rst_sync;
	sac_reg_s s;
	sac_reg_s next_s;
	logic acc;
	logic csr_wr;
	logic res_rd;

	////////////////////////////////////////////////////////////////////////
	// reset release
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [2:0] bitpos;
		logic setup;
		logic wr;
		logic [SAC_DATA_W-1:0] trial;
		next_s = s;
		bitpos = 3'(SAC_CONV_TICKS - 1 - int'(s.step));
		trial = s.sar;
		next_s.rsp.pready = 1'b0;
		next_s.evt_done = 1'b0;
		setup = apb_in.psel & apb_in.penable & ~s.rsp.pready;
		acc = apb_in.psel & apb_in.penable & s.rsp.pready;
		wr = acc & apb_in.pwrite;
		csr_wr = wr && (apb_in.paddr == SAC_CSR_ADDR);
		res_rd = acc && !apb_in.pwrite && (apb_in.paddr == SAC_RESULT_ADDR);

		// bus answer, one wait cycle
		if (setup) begin
			next_s.rsp.pready = 1'b1;
			next_s.rsp.pslverr = 1'b0;
			next_s.rsp.prdata = 32'h0;
			unique case (apb_in.paddr)
				SAC_RESULT_ADDR: next_s.rsp.prdata = {24'h0, s.result};
				SAC_CSR_ADDR: next_s.rsp.prdata =
					{24'h0, s.done, 1'b0, s.on, 1'b0, s.ch};
				SAC_ISTAT_ADDR: next_s.rsp.prdata = {30'h0, s.ist};
				SAC_ICLR_ADDR: next_s.rsp.prdata = 32'h0;
				SAC_IEN_ADDR: next_s.rsp.prdata = {30'h0, s.ien};
				SAC_PIN_ADDR: next_s.rsp.prdata = {16'h0, s.pins};
				default: next_s.rsp.pslverr = 1'b1;
			endcase
		end

		// register writes and read side effects
		if (csr_wr) begin
			next_s.on = apb_in.pwdata[SAC_ON_BIT];
			next_s.ch = apb_in.pwdata[SAC_CH_LSB +: SAC_CH_W];
			next_s.done = 1'b0;
		end
		if (res_rd) begin
			next_s.done = 1'b0;
		end
		if (wr && apb_in.paddr == SAC_ICLR_ADDR) begin
			next_s.ist = s.ist & ~apb_in.pwdata[SAC_EV_W-1:0];
		end
		if (wr && apb_in.paddr == SAC_IEN_ADDR) begin
			next_s.ien = apb_in.pwdata[SAC_EV_W-1:0];
		end
		next_s.pins = pin_level_in;

		// converter sequencing; wait mode is not an input at all
		next_s.div = ~s.div;
		if (s.div) begin
			unique case (s.st)
				SAC_SAMPLE: begin
					next_s.step = s.step + 4'h1;
					if (s.step == 4'(SAC_SAMPLE_TICKS - 1)) begin
						next_s.st = SAC_CONVERT;
						next_s.sar = SAC_SAR_FIRST;
					end
				end
				SAC_CONVERT: begin
					// keep the trial bit only if input is at or above it
					trial[bitpos] = cmp_in;
					if (bitpos != 3'h0) begin
						trial[bitpos - 3'h1] = 1'b1;
					end
					next_s.sar = trial;
					next_s.step = s.step + 4'h1;
					if (s.step == 4'(SAC_CONV_TICKS - 1)) begin
						next_s.result = trial;
						next_s.done = 1'b1;
						next_s.ist[SAC_EV_DONE] = 1'b1;
						next_s.evt_done = 1'b1;
						next_s.st = SAC_SAMPLE;
						next_s.step = 4'h0;
						next_s.sar = '0;
					end
				end
				default: ;
			endcase
		end

		// halt, abort and restart take precedence over sequencing
		if (halt_in) begin
			if (s.on) begin
				next_s.st = SAC_STAB;
				next_s.stab = STAB_W'(STAB_CYC);
			end
		end else if (csr_wr) begin
			if (s.st == SAC_SAMPLE || s.st == SAC_CONVERT) begin
				next_s.ist[SAC_EV_ABORT] = 1'b1;
			end
			if (apb_in.pwdata[SAC_ON_BIT] && s.st != SAC_STAB) begin
				next_s.st = SAC_SAMPLE;
				next_s.step = 4'h0;
				next_s.div = 1'b0;
				next_s.sar = '0;
			end
		end else if (s.st == SAC_STAB) begin
			if (s.stab == '0) begin
				next_s.st = SAC_SAMPLE;
				next_s.step = 4'h0;
				next_s.div = 1'b0;
				next_s.sar = '0;
			end else begin
				next_s.stab = s.stab - STAB_W'(1);
			end
		end
		if (!next_s.on) begin
			next_s.st = SAC_OFF;
			next_s.sar = '0;
		end

		// registered outputs
		next_s.ana.power_on = next_s.on & ~halt_in;
		next_s.ana.sample = (next_s.st == SAC_SAMPLE);
		next_s.ana.mux_sel = next_s.ch;
		next_s.ana.dac_code = next_s.sar;
		next_s.irq = |(next_s.ist & next_s.ien);
	end

	always_ff @(posedge mclk_in or negedge rst_sync) begin
		if (!rst_sync) begin
			s <= '0;
			s.result <= SAC_RESULT_RESET;
			{s.done, s.on, s.ch} <= {SAC_CSR_RESET[7], SAC_CSR_RESET[5],
				SAC_CSR_RESET[3:0]};
			s.st <= SAC_OFF;
		end else begin
			s <= next_s;
		end
	end

	assign apb_out = s.rsp;
	assign ana_out = s.ana;
	assign irq_out = s.irq;

	////////////////////////////////////////////////////////////////////////
	// checks
	logic [4:0] per_cnt;
	logic per_vld;

	always_ff @(posedge mclk_in or negedge rst_sync) begin
		if (!rst_sync) begin
			per_cnt <= 5'h0;
			per_vld <= 1'b0;
		end else if (s.evt_done) begin
			per_cnt <= 5'h0;
			per_vld <= 1'b1;
		end else if (halt_in || csr_wr) begin
			per_vld <= 1'b0;
		end else begin
			per_cnt <= per_cnt + 5'h1;
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_sync);

	sequence seq_csr_on;
		csr_wr && apb_in.pwdata[SAC_ON_BIT] && !halt_in && s.st != SAC_STAB;
	endsequence

	sequence seq_fresh_sample;
		ana_out.sample && s.step == 4'h0 && !s.div;
	endsequence

	chk_conv_period: assert property (
		s.evt_done && per_vld |-> per_cnt == 5'd23)
		else $error("conversion period is not 24 clocks");

	chk_sample_len: assert property (
		$fell(ana_out.sample) && s.st == SAC_CONVERT
			|-> $past(ana_out.sample, 8))
		else $error("sample phase is not 8 clocks");

	chk_restart_seq: assert property (
		seq_csr_on |=> seq_fresh_sample ##1 ana_out.sample)
		else $error("control write did not restart sampling");

	chk_result_hold: assert property (
		$changed(s.result) |-> s.done && $past(s.st) == SAC_CONVERT)
		else $error("result changed outside a conversion end");

	chk_done_wr_clear: assert property (
		csr_wr |=> !s.done)
		else $error("done flag survived a control write");

	chk_done_rd_clear: assert property (
		res_rd && !next_s.evt_done |=> !s.done)
		else $error("done flag survived a result read");

	chk_off_idle: assert property (
		csr_wr && !apb_in.pwdata[SAC_ON_BIT]
			|=> s.st == SAC_OFF && !ana_out.power_on ##1 !ana_out.sample)
		else $error("converter still active after switch off");

	chk_halt_stop: assert property (
		halt_in && s.on |=> !ana_out.power_on && s.st == SAC_STAB)
		else $error("converter not disabled by halt");

	chk_done_evt: assert property (
		s.evt_done |-> s.done && s.ist[SAC_EV_DONE])
		else $error("conversion end did not raise done");

	chk_irq_level: assert property (
		##1 irq_out == $past(|(next_s.ist & next_s.ien)))
		else $error("interrupt line disagrees with status and enable");

endmodule : sac_ctrl

// ### tb/sac_ana_model.sv
/* Far-side model: input mux, sample/hold and comparator.
   Assumes the bench supplies sixteen 8-bit input levels, packed. */
module sac_ana_model
	import sac_pkg::*;
(
	input wire logic mclk_in,
	input wire sac_ana_s ana_in,
	input wire logic [127:0] levels_in,
	output logic cmp_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] held = 8'h00;
	logic last = 1'b0;
	always @(posedge mclk_in) begin
		if (ana_in.sample) begin
			held <= levels_in[ana_in.mux_sel * 8 +: 8];
		end
		last <= cmp_out;
	end
	// no valid decision while unpowered or sampling: toggle
	assign cmp_out = (ana_in.power_on && !ana_in.sample) ?
		(held >= ana_in.dac_code) : ~last;
endmodule : sac_ana_model

// ### tb/tb_top.sv
/* Self-checking bench of the converter control block over APB.
   Assumes the far-side model answers the comparator input. */
module tb_top;
	import sac_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic halt_in = 1'b0;
	logic cmp;
	logic irq_out;
	logic [15:0] pins = 16'hA5C3;
	logic [127:0] levels = '0;
	sac_apb_req_s apb_req = '0;
	sac_apb_rsp_s apb_rsp;
	sac_ana_s ana;
	int bad_count = 0;
	int checks_done = 0;
	int n;
	logic [31:0] d;
	logic e;
	sac_ctrl #(.STAB_CYC(2)) u_sac_ctrl (.mclk_in(mclk_in),
		.rst_b_in(rst_b_in), .apb_in(apb_req), .apb_out(apb_rsp),
		.cmp_in(cmp), .halt_in(halt_in), .pin_level_in(pins),
		.ana_out(ana), .irq_out(irq_out));
	sac_ana_model u_sac_ana_model (.mclk_in(mclk_in), .ana_in(ana),
		.levels_in(levels), .cmp_out(cmp));
	initial begin
		forever #20 mclk_in = ~mclk_in;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge mclk_in);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
			pwdata: wd};
		@(posedge mclk_in);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge mclk_in);
			k++;
		end while (apb_rsp.pready !== 1'b1 && k < 50);
		if (k >= 50) bad_count++;
		d = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : xfer
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk({31'h0, e}, 32'h0);
		chk(d, exp);
	endtask : rd
	task automatic wait_done();
		int k;
		k = 0;
		do begin
			xfer(1'b0, SAC_CSR_ADDR, 32'h0);
			k++;
		end while (d[7] !== 1'b1 && k < 40);
		chk({31'h0, d[7]}, 32'h1);
	endtask : wait_done
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	initial begin
		#1_000_000;
		bad_count++;
		complete_run();
	end
	initial begin
		for (int ch = 0; ch < 16; ch++) begin
			levels[ch * 8 +: 8] = 8'(8'hFF - ch * 17);
		end
		repeat (2) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		rd(SAC_CSR_ADDR, 32'h0);
		rd(SAC_RESULT_ADDR, 32'h0);
		rd(SAC_PIN_ADDR, 32'hA5C3);
		xfer(1'b0, 12'h000, 32'h0);
		chk({31'h0, e}, 32'h1);
		for (int ch = 0; ch < 16; ch++) begin
			xfer(1'b1, SAC_CSR_ADDR, 32'h20 | ch);
			wait_done();
			rd(SAC_RESULT_ADDR, 32'hFF - ch * 17);
			rd(SAC_CSR_ADDR, 32'h20 | ch);
		end
		chk({31'h0, irq_out}, 32'h0);
		@(negedge ana.sample);
		#1 chk({24'h0, ana.dac_code}, 32'h80);
		n = 0;
		do begin @(posedge mclk_in); #1 n++; end while (!ana.sample);
		chk(n, 16);
		n = 0;
		do begin @(posedge mclk_in); #1 n++; end while (ana.sample);
		chk(n, 8);
		wait_done();
		levels[127:120] = 8'h3C;
		rd(SAC_RESULT_ADDR, 32'h00);
		wait_done();
		rd(SAC_RESULT_ADDR, 32'h00);
		wait_done();
		rd(SAC_RESULT_ADDR, 32'h3C);
		xfer(1'b1, SAC_ICLR_ADDR, 32'h3);
		xfer(1'b1, SAC_CSR_ADDR, 32'hAF);
		rd(SAC_CSR_ADDR, 32'h2F);
		xfer(1'b0, SAC_ISTAT_ADDR, 32'h0);
		chk(d & 32'h2, 32'h2);
		xfer(1'b1, SAC_IEN_ADDR, 32'h1);
		wait_done();
		chk({31'h0, irq_out}, 32'h1);
		xfer(1'b1, SAC_CSR_ADDR, 32'h00);
		xfer(1'b1, SAC_ICLR_ADDR, 32'h3);
		@(posedge mclk_in);
		#1 chk({31'h0, irq_out}, 32'h0);
		chk({31'h0, ana.power_on}, 32'h0);
		rd(SAC_ISTAT_ADDR, 32'h0);
		xfer(1'b1, SAC_CSR_ADDR, 32'h25);
		@(posedge mclk_in);
		halt_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		#1 chk({31'h0, ana.power_on}, 32'h0);
		@(posedge mclk_in);
		halt_in <= 1'b0;
		wait_done();
		rd(SAC_RESULT_ADDR, 32'hAA);
		complete_run();
	end
endmodule : tb_top
